// ---- ddbc_defines.svh ----
// Timing and geometry constants for the bank command state checker.
// Assumes the memory clock period below matches the command bus clock.
`ifndef DDBC_DEFINES_SVH
`define DDBC_DEFINES_SVH

`define DDBC_NBANK 4
`define DDBC_MCK_PERIOD_NS 160
// Least times of the bank, in ns
`define DDBC_T_RP_NS 15
`define DDBC_T_RCD_NS 15
`define DDBC_T_WR_NS 15
`define DDBC_T_RC_NS 60
`define DDBC_T_MRD_NS 20
// Same times as memory clock counts, rounded up
`define DDBC_RP_CYC ((`DDBC_T_RP_NS+`DDBC_MCK_PERIOD_NS-1)/`DDBC_MCK_PERIOD_NS)
`define DDBC_RCD_CYC ((`DDBC_T_RCD_NS+`DDBC_MCK_PERIOD_NS-1)/`DDBC_MCK_PERIOD_NS)
`define DDBC_WR_CYC ((`DDBC_T_WR_NS+`DDBC_MCK_PERIOD_NS-1)/`DDBC_MCK_PERIOD_NS)
`define DDBC_RC_CYC ((`DDBC_T_RC_NS+`DDBC_MCK_PERIOD_NS-1)/`DDBC_MCK_PERIOD_NS)
`define DDBC_MRD_CYC ((`DDBC_T_MRD_NS+`DDBC_MCK_PERIOD_NS-1)/`DDBC_MCK_PERIOD_NS)
// Burst lengths in clocks, and the count at the 4-bit boundary
`define DDBC_BL4_CYC 2
`define DDBC_BL8_CYC 4
`define DDBC_BND_CNT 3

`endif

// ---- ddbc_pkg.sv ----
// Types for the bank command state checker.
// Assumes ddbc_defines.svh supplies all numeric constants.
package ddbc_pkg;

  // Command bus pins as sampled at a memory clock edge
  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [1:0] ba;
    logic a10;
  } ddbc_cmd_pins_t;

  // Decoded commands
  typedef enum logic [3:0] {
    DDBC_C_DSL = 4'h0,
    DDBC_C_NOP = 4'h1,
    DDBC_C_RD = 4'h2,
    DDBC_C_WR = 4'h3,
    DDBC_C_ACT = 4'h4,
    DDBC_C_PRE = 4'h5,
    DDBC_C_REF = 4'h6,
    DDBC_C_MRS = 4'h7,
    DDBC_C_RSV = 4'h8
  } ddbc_cmd_t;

  // Per-bank states
  typedef enum logic [3:0] {
    DDBC_B_IDLE = 4'h0,
    DDBC_B_ACTG = 4'h1,
    DDBC_B_ACTIVE = 4'h2,
    DDBC_B_READ = 4'h3,
    DDBC_B_WRITE = 4'h4,
    DDBC_B_READ_AP = 4'h5,
    DDBC_B_WRITE_AP = 4'h6,
    DDBC_B_WREC = 4'h7,
    DDBC_B_WREC_AP = 4'h8,
    DDBC_B_PRECH = 4'h9
  } ddbc_bank_st_t;

  // Device-wide states
  typedef enum logic [1:0] {
    DDBC_G_NONE = 2'h0,
    DDBC_G_REF = 2'h1,
    DDBC_G_MRS = 2'h2
  } ddbc_glob_st_t;

endpackage

// ---- ddbc_bank_check.sv ----
// Bank command state checker: tracks every bank from the command bus and
// flags commands that the bank or device state does not allow.
// Assumes a controller drives the command pins on mem_clk_in.
// Functional notes
// [RL1] Decode commands from chip select and strobes
// [RL2] Auto-precharge burst runs out; others illegal
// [RL3] Precharging: NOP or PRE, idle after tRP
// [RL4] Row activating: NOP only, active after tRCD
// [RL5] Write recovering: active after tWR; new write
// [RL6] Write recovering auto-precharge: precharge after tWR
// [RL7] Refreshing: NOP only, idle after tRC
// [RL8] Mode register access: NOP only, idle after tMRD
// [RL9] Illegal bank command allowed to other banks
// [RL10] Refresh and mode set need all banks idle
// [RL11] No burst interruption at burst length four
// [RL12] Interrupt only by read/write on boundary
`timescale 1ns/1ps
`include "ddbc_defines.svh"

module ddbc_bank_check (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic mem_clk_in,
  input wire ddbc_pkg::ddbc_cmd_pins_t cmd_in,
  input wire logic bl8_in,
  output logic [`DDBC_NBANK-1:0] bank_idle_out,
  output logic illegal_out
);

  // Decode pin levels into a command
  function automatic ddbc_pkg::ddbc_cmd_t decode(ddbc_pkg::ddbc_cmd_pins_t p);
    if (p.cs_b) begin
      decode = ddbc_pkg::DDBC_C_DSL; // see [RL1]
    end else begin
      case ({p.ras_b, p.cas_b, p.we_b})
        3'h7: decode = ddbc_pkg::DDBC_C_NOP;
        3'h5: decode = ddbc_pkg::DDBC_C_RD;
        3'h4: decode = ddbc_pkg::DDBC_C_WR;
        3'h3: decode = ddbc_pkg::DDBC_C_ACT;
        3'h2: decode = ddbc_pkg::DDBC_C_PRE;
        3'h1: decode = ddbc_pkg::DDBC_C_REF;
        3'h0: decode = ddbc_pkg::DDBC_C_MRS;
        default: decode = ddbc_pkg::DDBC_C_RSV;
      endcase
    end
  endfunction
  // Read or write allowed in this bank state
  function automatic logic rw_ok(ddbc_pkg::ddbc_bank_st_t s, logic [7:0] c,
                                 logic wr, logic bl8);
    logic edge_ok;
    edge_ok = (c == 8'h01) || (bl8 && c == 8'(`DDBC_BND_CNT)); // see [RL11]
    case (s)
      ddbc_pkg::DDBC_B_ACTIVE: rw_ok = 1'b1;
      ddbc_pkg::DDBC_B_READ: rw_ok = !wr && edge_ok; // see [RL12]
      ddbc_pkg::DDBC_B_WRITE: rw_ok = wr && edge_ok; // see [RL12]
      ddbc_pkg::DDBC_B_WREC: rw_ok = wr; // see [RL5]
      default: rw_ok = 1'b0; // see [RL2]
    endcase
  endfunction
  // State reached when a timed bank state runs out
  function automatic ddbc_pkg::ddbc_bank_st_t after(ddbc_pkg::ddbc_bank_st_t s);
    case (s)
      ddbc_pkg::DDBC_B_READ: after = ddbc_pkg::DDBC_B_ACTIVE;
      ddbc_pkg::DDBC_B_READ_AP: after = ddbc_pkg::DDBC_B_PRECH;
      ddbc_pkg::DDBC_B_WRITE: after = ddbc_pkg::DDBC_B_WREC;
      ddbc_pkg::DDBC_B_WRITE_AP: after = ddbc_pkg::DDBC_B_WREC_AP;
      ddbc_pkg::DDBC_B_WREC: after = ddbc_pkg::DDBC_B_ACTIVE; // see [RL5]
      ddbc_pkg::DDBC_B_WREC_AP: after = ddbc_pkg::DDBC_B_PRECH; // see [RL6]
      ddbc_pkg::DDBC_B_PRECH: after = ddbc_pkg::DDBC_B_IDLE; // see [RL3]
      ddbc_pkg::DDBC_B_ACTG: after = ddbc_pkg::DDBC_B_ACTIVE; // see [RL4]
      default: after = s;
    endcase
  endfunction

  // Count loaded on entering a timed state
  function automatic logic [7:0] load(ddbc_pkg::ddbc_bank_st_t s);
    case (s)
      ddbc_pkg::DDBC_B_WREC: load = 8'(`DDBC_WR_CYC);
      ddbc_pkg::DDBC_B_WREC_AP: load = 8'(`DDBC_WR_CYC);
      ddbc_pkg::DDBC_B_PRECH: load = 8'(`DDBC_RP_CYC);
      ddbc_pkg::DDBC_B_ACTG: load = 8'(`DDBC_RCD_CYC);
      default: load = 8'h00;
    endcase
  endfunction

  // Reset release chains, one per domain
  logic [1:0] crst_r, mrst_r;
  logic crst_b, mrst_b; // Released resets
  assign crst_b = crst_r[1];
  assign mrst_b = mrst_r[1];

  // Core domain reset release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) crst_r <= 2'h0;
    else crst_r <= {crst_r[0], 1'b1};
  end

  // Memory domain reset release
  always_ff @(posedge mem_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) mrst_r <= 2'h0;
    else mrst_r <= {mrst_r[0], 1'b1};
  end

  // Memory domain state
  ddbc_pkg::ddbc_cmd_pins_t pins_r; // Captured command pins
  logic [1:0] bl8_r, bl8_nxt; // Burst length mode synchroniser
  ddbc_pkg::ddbc_bank_st_t st_r [`DDBC_NBANK], st_nxt [`DDBC_NBANK];
  logic [7:0] cnt_r [`DDBC_NBANK], cnt_nxt [`DDBC_NBANK]; // Bank timers
  ddbc_pkg::ddbc_glob_st_t g_r, g_nxt; // Refresh or mode access
  logic [7:0] gcnt_r, gcnt_nxt;
  logic bad_r, bad_nxt; // Illegal command seen last edge
  logic tgl_r, tgl_nxt; // Toggles per illegal command
  logic [`DDBC_NBANK-1:0] idle_r, idle_nxt;
  ddbc_pkg::ddbc_cmd_t cmd;
  logic all_idle, nopish; // All banks idle; deselect or NOP
  int b;

  assign cmd = decode(pins_r);
  assign b = int'(pins_r.ba);
  assign nopish = (cmd == ddbc_pkg::DDBC_C_DSL) || (cmd == ddbc_pkg::DDBC_C_NOP);

  // Next bank and device state from timers and the command
  always_comb begin
    bl8_nxt = {bl8_r[0], bl8_in};
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    g_nxt = g_r;
    gcnt_nxt = gcnt_r;
    bad_nxt = 1'b0;
    all_idle = 1'b1;
    for (int i = 0; i < `DDBC_NBANK; i++) begin
      if (st_r[i] != ddbc_pkg::DDBC_B_IDLE) all_idle = 1'b0;
      // Timed states count down and move on
      if (after(st_r[i]) != st_r[i]) begin
        if (cnt_r[i] <= 8'h01) begin
          st_nxt[i] = after(st_r[i]); // see [RL3] [RL4] [RL5] [RL6]
          cnt_nxt[i] = load(after(st_r[i]));
        end else begin
          cnt_nxt[i] = cnt_r[i] - 8'h01;
        end
      end
    end
    // Device-wide timer
    if (g_r != ddbc_pkg::DDBC_G_NONE) begin
      if (gcnt_r <= 8'h01) g_nxt = ddbc_pkg::DDBC_G_NONE; // see [RL7] [RL8]
      else gcnt_nxt = gcnt_r - 8'h01;
    end
    if (g_r != ddbc_pkg::DDBC_G_NONE) begin
      bad_nxt = !nopish; // see [RL7] [RL8]
    end else begin
      case (cmd)
        ddbc_pkg::DDBC_C_DSL, ddbc_pkg::DDBC_C_NOP: bad_nxt = 1'b0;
        // Only the addressed bank is judged
        ddbc_pkg::DDBC_C_RD, ddbc_pkg::DDBC_C_WR: begin
          if (rw_ok(st_r[b], cnt_r[b], cmd == ddbc_pkg::DDBC_C_WR,
                    bl8_r[1])) begin // see [RL9]
            if (cmd == ddbc_pkg::DDBC_C_WR)
              st_nxt[b] = pins_r.a10 ? ddbc_pkg::DDBC_B_WRITE_AP :
                          ddbc_pkg::DDBC_B_WRITE;
            else
              st_nxt[b] = pins_r.a10 ? ddbc_pkg::DDBC_B_READ_AP :
                          ddbc_pkg::DDBC_B_READ;
            cnt_nxt[b] = bl8_r[1] ? 8'(`DDBC_BL8_CYC) : 8'(`DDBC_BL4_CYC);
          end else begin
            bad_nxt = 1'b1; // see [RL2] [RL11] [RL12]
          end
        end
        ddbc_pkg::DDBC_C_ACT: begin
          if (st_r[b] == ddbc_pkg::DDBC_B_IDLE) begin
            st_nxt[b] = ddbc_pkg::DDBC_B_ACTG;
            cnt_nxt[b] = load(ddbc_pkg::DDBC_B_ACTG);
          end else begin
            bad_nxt = 1'b1; // see [RL4]
          end
        end
        // Precharge one bank, or all when a10 is high
        ddbc_pkg::DDBC_C_PRE: begin
          for (int i = 0; i < `DDBC_NBANK; i++) begin
            if (pins_r.a10 || i == b) begin
              if (st_r[i] == ddbc_pkg::DDBC_B_ACTIVE) begin
                st_nxt[i] = ddbc_pkg::DDBC_B_PRECH;
                cnt_nxt[i] = load(ddbc_pkg::DDBC_B_PRECH);
              end else if (st_r[i] != ddbc_pkg::DDBC_B_IDLE &&
                           st_r[i] != ddbc_pkg::DDBC_B_PRECH) begin
                bad_nxt = 1'b1; // see [RL3]
              end
            end
          end
        end
        ddbc_pkg::DDBC_C_REF, ddbc_pkg::DDBC_C_MRS: begin
          if (all_idle) begin // see [RL10]
            g_nxt = (cmd == ddbc_pkg::DDBC_C_REF) ? ddbc_pkg::DDBC_G_REF :
                    ddbc_pkg::DDBC_G_MRS;
            gcnt_nxt = (cmd == ddbc_pkg::DDBC_C_REF) ? 8'(`DDBC_RC_CYC) :
                       8'(`DDBC_MRD_CYC);
          end else begin
            bad_nxt = 1'b1;
          end
        end
        default: bad_nxt = 1'b1;
      endcase
    end
    tgl_nxt = tgl_r ^ bad_nxt;
    for (int i = 0; i < `DDBC_NBANK; i++)
      idle_nxt[i] = (st_nxt[i] == ddbc_pkg::DDBC_B_IDLE);
  end

  // Memory domain registers
  always_ff @(posedge mem_clk_in or negedge mrst_b) begin
    if (!mrst_b) begin
      pins_r <= '1;
      bl8_r <= 2'h0;
      for (int i = 0; i < `DDBC_NBANK; i++) begin
        st_r[i] <= ddbc_pkg::DDBC_B_IDLE;
        cnt_r[i] <= 8'h00;
      end
      g_r <= ddbc_pkg::DDBC_G_NONE;
      gcnt_r <= 8'h00;
      bad_r <= 1'b0;
      tgl_r <= 1'b0;
      idle_r <= '1;
    end else begin
      pins_r <= cmd_in;
      bl8_r <= bl8_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      g_r <= g_nxt;
      gcnt_r <= gcnt_nxt;
      bad_r <= bad_nxt;
      tgl_r <= tgl_nxt;
      idle_r <= idle_nxt;
    end
  end

  // Core domain: idle levels through three flops, illegal event by toggle
  logic [`DDBC_NBANK-1:0] idle_s1_r, idle_s2_r;
  logic [2:0] tgl_s_r;
  always_ff @(posedge clk_in or negedge crst_b) begin
    if (!crst_b) begin
      idle_s1_r <= '1;
      idle_s2_r <= '1;
      tgl_s_r <= 3'h0;
      bank_idle_out <= '1;
      illegal_out <= 1'b0;
    end else begin
      idle_s1_r <= idle_r;
      idle_s2_r <= idle_s1_r;
      bank_idle_out <= idle_s2_r;
      tgl_s_r <= {tgl_s_r[1:0], tgl_r};
      illegal_out <= tgl_s_r[2] ^ tgl_s_r[1];
    end
  end

  // Checks on the memory domain
  default clocking @(posedge mem_clk_in); endclocking
  default disable iff (!mrst_b);

  dsl_decode_a: assert property (pins_r.cs_b |-> cmd == ddbc_pkg::DDBC_C_DSL) // see [RL1]
    else $error("deselect not decoded");
  ap_burst_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_READ_AP && // see [RL2]
      g_r == ddbc_pkg::DDBC_G_NONE && !nopish && b == 0 |=> bad_r)
    else $error("command during auto-precharge burst accepted");
  prech_idle_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_PRECH && // see [RL3]
      cnt_r[0] == 8'h01 && cmd != ddbc_pkg::DDBC_C_RD |=>
      st_r[0] == ddbc_pkg::DDBC_B_IDLE)
    else $error("precharge did not end in idle");
  actg_bad_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_ACTG && // see [RL4]
      g_r == ddbc_pkg::DDBC_G_NONE && !nopish && b == 0 |=>
      bad_r && $past(st_r[0]) == ddbc_pkg::DDBC_B_ACTG)
    else $error("command during row activation accepted");
  wrec_new_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_WREC && // see [RL5]
      g_r == ddbc_pkg::DDBC_G_NONE && cmd == ddbc_pkg::DDBC_C_WR &&
      b == 0 && !pins_r.a10 |=> !bad_r && st_r[0] == ddbc_pkg::DDBC_B_WRITE)
    else $error("new write in recovery refused");
  wrecap_pre_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_WREC_AP && // see [RL6]
      cnt_r[0] == 8'h01 |=> st_r[0] == ddbc_pkg::DDBC_B_PRECH)
    else $error("write recovery did not precharge");
  ref_only_nop_a: assert property (g_r == ddbc_pkg::DDBC_G_REF && !nopish // see [RL7]
      |=> bad_r)
    else $error("command during refresh accepted");
  mrs_end_a: assert property (g_r == ddbc_pkg::DDBC_G_MRS && // see [RL8]
      gcnt_r == 8'h01 |=> g_r == ddbc_pkg::DDBC_G_NONE)
    else $error("mode access did not end");
  bl4_int_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_READ && !bl8_r[1] && // see [RL11]
      cnt_r[0] > 8'h01 && cmd == ddbc_pkg::DDBC_C_RD && b == 0 &&
      g_r == ddbc_pkg::DDBC_G_NONE |=> bad_r)
    else $error("burst of four interrupted");
  bnd_int_a: assert property (st_r[0] == ddbc_pkg::DDBC_B_READ && bl8_r[1] && // see [RL12]
      cnt_r[0] == 8'(`DDBC_BND_CNT) && cmd == ddbc_pkg::DDBC_C_RD && b == 0 &&
      g_r == ddbc_pkg::DDBC_G_NONE |=> !bad_r ##1 cnt_r[0] < 8'(`DDBC_BL8_CYC))
    else $error("boundary interruption refused");

  ref_seen_c: cover property (g_r == ddbc_pkg::DDBC_G_REF ##1
      g_r == ddbc_pkg::DDBC_G_NONE);
  wr_ap_c: cover property (st_r[0] == ddbc_pkg::DDBC_B_WREC_AP ##1
      st_r[0] == ddbc_pkg::DDBC_B_PRECH);
  interrupt_c: cover property (st_r[0] == ddbc_pkg::DDBC_B_READ && bl8_r[1] &&
      cnt_r[0] == 8'(`DDBC_BND_CNT) && cmd == ddbc_pkg::DDBC_C_RD && b == 0);

endmodule // ddbc_bank_check

// ---- ddbc_ctl_model.sv ----
// Controller model that plays queued commands onto the command bus.
// Assumes the bench queues only orders it wants judged, one per clock.
`timescale 1ns/1ps
module ddbc_ctl_model (
  input wire logic mem_clk_in,
  output ddbc_pkg::ddbc_cmd_pins_t cmd_out = 7'h7f,
  output logic exp_out = 1'b0
);
  // Pending commands and their expected verdicts
  ddbc_pkg::ddbc_cmd_pins_t q_cmd[$];
  logic q_exp[$];

  // Queue one command with its expected illegal flag
  task automatic push(input ddbc_pkg::ddbc_cmd_pins_t c, input logic e);
    q_cmd.push_back(c);
    q_exp.push_back(e);
  endtask

  // Commands still waiting for the bus
  function automatic int pending();
    return q_cmd.size();
  endfunction

  // One command per clock, launched just after the edge
  always @(posedge mem_clk_in) begin
    if (q_cmd.size() > 0) begin
      cmd_out <= q_cmd.pop_front();
      exp_out <= q_exp.pop_front();
    end else begin
      // Deselect; stale pins flip so they never look valid
      cmd_out <= {1'b1, ~cmd_out[5:0]};
      exp_out <= 1'b0;
    end
  end
endmodule // ddbc_ctl_model

// ---- tb.sv ----
// Self-checking bench for the bank command checker.
// Assumes each illegal pulse lands before the second edge after capture.
`timescale 1ns/1ps
`include "ddbc_defines.svh"
module tb;
  localparam ddbc_pkg::ddbc_cmd_t DSL = ddbc_pkg::DDBC_C_DSL;
  localparam ddbc_pkg::ddbc_cmd_t NOP = ddbc_pkg::DDBC_C_NOP;
  localparam ddbc_pkg::ddbc_cmd_t RD = ddbc_pkg::DDBC_C_RD;
  localparam ddbc_pkg::ddbc_cmd_t WR = ddbc_pkg::DDBC_C_WR;
  localparam ddbc_pkg::ddbc_cmd_t ACT = ddbc_pkg::DDBC_C_ACT;
  localparam ddbc_pkg::ddbc_cmd_t PRE = ddbc_pkg::DDBC_C_PRE;
  localparam ddbc_pkg::ddbc_cmd_t REF = ddbc_pkg::DDBC_C_REF;
  localparam ddbc_pkg::ddbc_cmd_t MRS = ddbc_pkg::DDBC_C_MRS;
  localparam ddbc_pkg::ddbc_cmd_t RSV = ddbc_pkg::DDBC_C_RSV;
  // Strobe pattern per command; deselect carries a read pattern
  localparam logic [2:0] OPS [0:8] = '{3'h5, 3'h7, 3'h5, 3'h4, 3'h3,
                                       3'h2, 3'h1, 3'h0, 3'h6};
  logic clk_in = 1'b0;
  logic mem_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic bl8_in = 1'b0;
  ddbc_pkg::ddbc_cmd_pins_t cmd;
  logic [`DDBC_NBANK-1:0] bank_idle;
  logic illegal;
  logic exp_w;
  logic p1 = 1'b0;
  logic p2 = 1'b0;
  logic chk_on = 1'b0;
  logic [1:0] b;
  int errors = 0;
  int cmp_count = 0;
  int pulses = 0;
  int seen = 0;
  int cyc = 0;

  ddbc_bank_check u_ddbc_bank_check (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mem_clk_in(mem_clk_in),
    .cmd_in(cmd),
    .bl8_in(bl8_in),
    .bank_idle_out(bank_idle),
    .illegal_out(illegal)
  );

  ddbc_ctl_model u_ddbc_ctl_model (
    .mem_clk_in(mem_clk_in),
    .cmd_out(cmd),
    .exp_out(exp_w)
  );

  // Core clock; memory clock offset so edges never coincide
  initial forever #5 clk_in = ~clk_in;
  initial begin
    #3;
    forever #80 mem_clk_in = ~mem_clk_in;
  end

  // Count pulses and cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (illegal === 1'b1) pulses++;
    if (cyc == 10000) begin
      errors++;
      conclude();
    end
  end

  // Pulses in each memory clock belong to the order of three edges ago
  always @(posedge mem_clk_in) begin
    if (chk_on) begin
      cmp_count++;
      if (pulses - seen != int'(p2)) begin
        errors++;
        $display("MISMATCH t=%0t pulses %h exp %h", $time, pulses - seen, p2);
      end
    end
    seen = pulses;
    p2 = p1;
    p1 = exp_w;
  end

  // Queue one command: kind, bank, a10, expected illegal flag
  task automatic c(input ddbc_pkg::ddbc_cmd_t k, input logic [1:0] bk,
                   input logic a, input logic e);
    u_ddbc_ctl_model.push({k == DSL, OPS[k], bk, a}, e);
  endtask

  // Drain the queue, then compare the idle banks
  task automatic fin(input string nm, input logic [3:0] m);
    int n = 0;
    while (u_ddbc_ctl_model.pending() > 0 && n < 200) begin
      @(posedge mem_clk_in);
      n++;
    end
    repeat (4) @(posedge mem_clk_in);
    cmp_count++;
    if (bank_idle !== m) begin
      errors++;
      $display("MISMATCH t=%0t idle %h exp %h", $time, bank_idle, m);
    end
    $display("Test %s done", nm);
  endtask

  // Report counts and end the run
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(62154));
    repeat (6) @(posedge mem_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mem_clk_in);
    chk_on = 1'b1;
    c(ACT, 0, 0, 0);
    c(PRE, 0, 0, 1);
    c(RD, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(DSL, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(PRE, 0, 0, 0);
    c(ACT, 0, 0, 1);
    c(PRE, 0, 0, 0);
    fin("act_prech", 4'hf);
    c(ACT, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(RD, 0, 1, 0);
    c(WR, 0, 0, 1);
    c(ACT, 2, 0, 0);
    fin("read_ap", 4'hb);
    c(ACT, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(WR, 0, 1, 0);
    c(NOP, 0, 0, 0);
    c(WR, 0, 0, 1);
    c(PRE, 2, 0, 0);
    fin("write_ap", 4'hf);
    c(ACT, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(WR, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(WR, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(RD, 0, 0, 1);
    repeat (3) c(NOP, 0, 0, 0);
    c(PRE, 0, 0, 0);
    fin("write_rec", 4'hf);
    c(ACT, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(RD, 0, 0, 0);
    c(RD, 0, 0, 1);
    repeat (3) c(NOP, 0, 0, 0);
    c(PRE, 0, 0, 0);
    fin("bl4", 4'hf);
    bl8_in <= 1'b1;
    c(ACT, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(RD, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(RD, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(RD, 0, 0, 1);
    repeat (5) c(NOP, 0, 0, 0);
    c(PRE, 0, 0, 0);
    fin("bl8", 4'hf);
    bl8_in <= 1'b0;
    c(REF, 0, 0, 0);
    c(ACT, 1, 0, 1);
    c(NOP, 0, 0, 0);
    c(MRS, 0, 0, 0);
    c(RD, 3, 0, 1);
    c(NOP, 0, 0, 0);
    c(ACT, 0, 0, 0);
    c(NOP, 0, 0, 0);
    c(REF, 0, 0, 1);
    c(MRS, 0, 0, 1);
    c(RSV, 0, 0, 1);
    c(PRE, 0, 1, 0);
    fin("ref_mrs", 4'hf);
    repeat (8) begin
      b = 2'($urandom);
      c(ACT, b, 1'($urandom), 0);
      c(ACT, b + 2'h1, 0, 0);
      c(DSL, b, 1'($urandom), 0);
      c(PRE, b, 1, 0);
      c(DSL, b, 0, 0);
    end
    fin("random", 4'hf);
    c(ACT, 3, 0, 0);
    fin("act3", 4'h7);
    rst_b_in <= 1'b0;
    repeat (4) @(posedge mem_clk_in);
    cmp_count++;
    if (bank_idle !== 4'hf) begin
      errors++;
      $display("MISMATCH t=%0t idle %h exp %h", $time, bank_idle, 4'hf);
    end
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mem_clk_in);
    fin("reset", 4'hf);
    conclude();
  end
endmodule // tb
